// >>> rtl/gatcc_ctrl.v
/*
 * gain amplifier trigger and clock control: axi4-lite register file,
 * charge-pump clock enable, gain clock enable and conversion sequencer.
 * assumes the adc source clock and hardware trigger arrive from another
 * domain and are synchronised here; the chip oscillator is clk_i.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
`include "gatcc_defines.vh"

// Function
// - calibration field: 00 normal, 10 offset
// - charge pump clock is osc over 2^divisor
// - charge-pump divisor resets to 2
// - software trigger write starts one conversion in software mode only
// - software trigger bit always reads zero
// - gain stages clocked pulse count plus one
// - pulse count resets to 3
// - divide codes give 1, 2, 4, 8
// - gain clock derived from converter source clock
// - hardware mode starts on trigger rising edge
module gatcc_ctrl (
   // clock and reset
   input  wire        clk_i,
   input  wire        reset_n_i,
   // axi4-lite write address and data
   input  wire [31:0] s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   // axi4-lite read
   input  wire [31:0] s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // converter side
   input  wire        adc_src_clk_i,
   input  wire        hw_trigger_i,
   // analog control
   output reg         sample_hold_bypass_o,
   output reg         offset_cal_o,
   output reg         charge_pump_clk_en_o,
   output reg         gain_clk_en_o,
   output reg         running_o
);

   // register state
   reg  [7:0] ctrl0;
   reg        sample_hold_bypass;
   reg  [1:0] calibration_select;
   reg  [2:0] charge_pump_divisor;
   reg  [2:0] gain_clock_pulse_count;
   reg  [1:0] clock_divide_select;
   reg        sw_trig_pulse;
   wire       trigger_mode_select = ctrl0[`GATCC_TM_BIT];

   // write channel holding registers, address and data taken apart
   reg        aw_held;
   reg  [3:0] aw_idx;
   reg        w_held;
   reg [31:0] w_data;
   reg  [3:0] w_strb;
   reg        ar_busy;

   // readies are combinational; a channel refuses while it holds an item
   assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
   assign s_axi_arready_o = !ar_busy;

   // the status word is read only, so a write to it answers slverr
   wire       do_write = aw_held && w_held && !s_axi_bvalid_o;
   wire       wr_ok    = (aw_idx <= `GATCC_IDX_CTRL2);
   wire       wr_lane0 = do_write && wr_ok && w_strb[0];

   // write address and data capture, then one response
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_held        <= 1'b0;
         aw_idx         <= 4'h0;
         w_held         <= 1'b0;
         w_data         <= 32'h0000_0000;
         w_strb         <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `GATCC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr_i[5:2];
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (do_write) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? `GATCC_RESP_OKAY : `GATCC_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // control registers; only byte lane 0 carries the 8-bit registers
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl0                  <= `GATCC_CTRL0_RST;
         sample_hold_bypass     <= 1'b0;
         calibration_select     <= `GATCC_CAL_NORMAL;
         charge_pump_divisor    <= `GATCC_CPD_RST;
         gain_clock_pulse_count <= `GATCC_NCLK_RST;
         clock_divide_select    <= `GATCC_DIV_RST;
         sw_trig_pulse          <= 1'b0;
      end else begin
         sw_trig_pulse <= 1'b0;
         if (wr_lane0 && aw_idx == `GATCC_IDX_CTRL0)
            ctrl0 <= w_data[7:0];
         if (wr_lane0 && aw_idx == `GATCC_IDX_CTRL1) begin
            // stored as written; software keeps it zero
            sample_hold_bypass  <= w_data[`GATCC_BP_BIT];
            calibration_select  <= w_data[`GATCC_CAL_HI:`GATCC_CAL_LO];
            charge_pump_divisor <= w_data[`GATCC_CPD_HI:`GATCC_CPD_LO];
         end
         if (wr_lane0 && aw_idx == `GATCC_IDX_CTRL2) begin
            gain_clock_pulse_count <= w_data[`GATCC_NCLK_HI:`GATCC_NCLK_LO];
            clock_divide_select    <= w_data[`GATCC_DIV_HI:`GATCC_DIV_LO];
            // trigger bit is a pulse, not stored
            sw_trig_pulse <= w_data[`GATCC_SWT_BIT] && trigger_mode_select;
         end
      end
   end

   // status passed through a two-stage sync clocked by clk_i
   // running_o is already a clk_i flop; the two stages only add lag
   reg        run_meta;
   reg        run_sync;

   // read data mux; reserved bits read zero
   reg  [7:0] rd_byte;
   reg        rd_ok;
   always @* begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (s_axi_araddr_i[5:2])
         `GATCC_IDX_CTRL0:  rd_byte = ctrl0;
         `GATCC_IDX_CTRL1:  rd_byte = {2'h0, sample_hold_bypass,
                                       calibration_select,
                                       charge_pump_divisor};
         // trigger bit position returns zero
         `GATCC_IDX_CTRL2:  rd_byte = {2'h0, 1'b0, gain_clock_pulse_count,
                                       clock_divide_select};
         `GATCC_IDX_STATUS: rd_byte = {6'h00, run_sync, 1'b0};
         default:           rd_ok   = 1'b0;
      endcase
   end

   // read channel, one cycle to answer
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= `GATCC_RESP_OKAY;
         ar_busy        <= 1'b0;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= {24'h000000, rd_byte};
         s_axi_rresp_o  <= rd_ok ? `GATCC_RESP_OKAY : `GATCC_RESP_SLVERR;
         ar_busy        <= 1'b1;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         ar_busy        <= 1'b0;
      end
   end

   // analog control levels
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sample_hold_bypass_o <= 1'b0;
         offset_cal_o         <= 1'b0;
      end else begin
         sample_hold_bypass_o <= sample_hold_bypass;
         // reserved codes fall back to normal operation
         offset_cal_o <= (calibration_select == `GATCC_CAL_OFFSET);
      end
   end

   // charge pump enable: one pulse every 2^divisor oscillator cycles
   // a new divisor applies at once, so the first period may be short
   reg  [6:0] cp_cnt;
   wire [6:0] cp_mask = (7'h01 << charge_pump_divisor) - 7'h01;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cp_cnt               <= 7'h00;
         charge_pump_clk_en_o <= 1'b0;
      end else begin
         cp_cnt               <= (cp_cnt + 7'h01) & cp_mask;
         charge_pump_clk_en_o <= ((cp_cnt & cp_mask) == cp_mask);
      end
   end

   // converter source clock and hardware trigger, two flops each
   reg  [1:0] src_sync;
   reg  [1:0] hwt_sync;
   reg        src_prev;
   reg        hwt_prev;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         src_sync <= 2'b00;
         hwt_sync <= 2'b00;
         src_prev <= 1'b0;
         hwt_prev <= 1'b0;
         run_meta <= 1'b0;
         run_sync <= 1'b0;
      end else begin
         src_sync <= {src_sync[0], adc_src_clk_i};
         hwt_sync <= {hwt_sync[0], hw_trigger_i};
         src_prev <= src_sync[1];
         hwt_prev <= hwt_sync[1];
         run_meta <= running_o;
         run_sync <= run_meta;
      end
   end
   // idle level of both pins is low, so reset leaves no false edge
   wire src_rise = src_sync[1] && !src_prev;
   wire hwt_rise = hwt_sync[1] && !hwt_prev;

   // gain clock: source rising edges divided by 1,2,4,8
   // the source must run below half of clk_i or edges are lost
   reg  [2:0] gdiv_cnt;
   wire [2:0] gdiv_mask = (3'h1 << clock_divide_select) - 3'h1;
   wire       gtick = src_rise && ((gdiv_cnt & gdiv_mask) == gdiv_mask);
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         gdiv_cnt <= 3'h0;
      else if (src_rise)
         gdiv_cnt <= (gdiv_cnt + 3'h1) & gdiv_mask;
   end

   // pending trigger held until the sequencer takes it
   reg        pend;
   wire       hw_start = hwt_rise && !trigger_mode_select;
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN  = 2'b10;
   reg  [1:0] state;
   reg  [3:0] pulses_left;

   // sequencer: count+1 gain clock pulses per conversion
   // a trigger during a run waits in pend, one deep; extra ones merge
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend          <= 1'b0;
         state         <= ST_IDLE;
         pulses_left   <= 4'h0;
         gain_clk_en_o <= 1'b0;
         running_o     <= 1'b0;
      end else begin
         gain_clk_en_o <= 1'b0;
         // a new trigger wins over the take, so none is lost
         if (sw_trig_pulse || hw_start)
            pend <= 1'b1;
         else if (state == ST_IDLE && gtick)
            pend <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (pend && gtick) begin
                  state         <= ST_RUN;
                  running_o     <= 1'b1;
                  gain_clk_en_o <= 1'b1;
                  pulses_left   <= {1'b0, gain_clock_pulse_count};
               end
            end
            ST_RUN: begin
               if (pulses_left == 4'h0) begin
                  state     <= ST_IDLE;
                  running_o <= 1'b0;
               end else if (gtick) begin
                  gain_clk_en_o <= 1'b1;
                  pulses_left   <= pulses_left - 4'h1;
               end
            end
            default: begin
               state     <= ST_IDLE;
               running_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // gatcc_ctrl
`default_nettype wire

// >>> rtl/gatcc_defines.vh
/*
 * register map, field positions, reset values and axi response codes for the
 * gain amplifier trigger and clock control block.
 * assumes a 32-bit axi4-lite slave with one register per word.
 */
`ifndef GATCC_DEFINES_VH
`define GATCC_DEFINES_VH

// register indices (word offsets), byte address is four times these
`define GATCC_IDX_CTRL0     4'h0
`define GATCC_IDX_CTRL1     4'h1
`define GATCC_IDX_CTRL2     4'h2
`define GATCC_IDX_STATUS    4'h3

// control register 0 fields
`define GATCC_TM_BIT        7
// control register 1 fields
`define GATCC_BP_BIT        5
`define GATCC_CAL_HI        4
`define GATCC_CAL_LO        3
`define GATCC_CPD_HI        2
`define GATCC_CPD_LO        0
// control register 2 fields
`define GATCC_SWT_BIT       5
`define GATCC_NCLK_HI       4
`define GATCC_NCLK_LO       2
`define GATCC_DIV_HI        1
`define GATCC_DIV_LO        0

// calibration codes
`define GATCC_CAL_NORMAL    2'h0
`define GATCC_CAL_OFFSET    2'h2

// reset values
`define GATCC_CTRL0_RST     8'h00
`define GATCC_CPD_RST       3'h2
`define GATCC_NCLK_RST      3'h3
`define GATCC_DIV_RST       2'h0

// axi responses
`define GATCC_RESP_OKAY     2'h0
`define GATCC_RESP_SLVERR   2'h2

`endif

// >>> tb/gatcc_adc_model.sv
/* converter side model: free source clock and hardware trigger.
   assumes the bench calls fire() once per hardware conversion. */
`default_nettype none
module gatcc_adc_model (
   // converter outputs
   output var logic src_clk_o,
   output var logic trig_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // eight clk periods per cycle, odd phase so no edge meets clk
   initial begin
      src_clk_o = 1'b0;
      #7;
      forever #160 src_clk_o = ~src_clk_o;
   end
   initial trig_o = 1'b0;
   // one rising edge, held long so the synchroniser cannot miss it
   task automatic fire();
      trig_o <= 1'b1;
      #400 trig_o <= 1'b0;
   endtask
endmodule // gatcc_adc_model
`default_nettype wire

// >>> tb/gatcc_ctrl_assertions.sv
/* bus handshake and conversion sequencing checks on the ports.
   assumes one clock domain and the active low reset. */
`default_nettype none
module gatcc_ctrl_assertions (
   // watched ports
   input wire logic        clk_i, reset_n_i, s_axi_awready_o,
   input wire logic        s_axi_bvalid_o, s_axi_bready_i,
   input wire logic        s_axi_arready_o, s_axi_rvalid_o,
   input wire logic        s_axi_rready_i, gain_clk_en_o, running_o,
   input wire logic [31:0] s_axi_rdata_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o) else $error("bvalid dropped early");
   chk_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o) else $error("rvalid dropped early");
   chk_rdata_stable: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> $stable(s_axi_rdata_o)) else $error("rdata moved");
   chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("arready during rvalid");
   chk_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
      else $error("awready during bvalid");
   chk_pulse_in_run: assert property (
      gain_clk_en_o |-> running_o) else $error("gain pulse outside run");
   chk_pulse_single: assert property (
      gain_clk_en_o |=> !gain_clk_en_o) else $error("gain pulse too long");
   chk_run_starts: assert property (
      $rose(running_o) |-> gain_clk_en_o)
      else $error("run without first pulse");
   cover property ($rose(running_o));
   cover property (s_axi_bvalid_o && s_axi_bready_i);
   cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // gatcc_ctrl_assertions
bind gatcc_ctrl gatcc_ctrl_assertions i_chk (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .gain_clk_en_o(gain_clk_en_o),
   .running_o(running_o), .s_axi_rdata_o(s_axi_rdata_o));
`default_nettype wire

// >>> tb/tb_top.sv
/* bench: axi4-lite register tasks, pulse counting per conversion.
   assumes the converter model gives one source cycle per 8 clk. */
`default_nettype none
`include "gatcc_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_i, reset_n_i, awv, wv, bry, arv, rry;
   logic [31:0]      awa, wd, ara, rdv;
   logic [3:0]       ws;
   logic [1:0]       rrv, brv;
   wire logic        awr, wr_o, bv, arr, rv, src, trg, shb, ofc, cpe;
   wire logic        gce, run;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rd;
   int               miscompares, checked, pulses, gap, last, n, cgap, clast;
   gatcc_ctrl i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr_o), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .adc_src_clk_i(src),
      .hw_trigger_i(trg), .sample_hold_bypass_o(shb), .offset_cal_o(ofc),
      .charge_pump_clk_en_o(cpe), .gain_clk_en_o(gce), .running_o(run));
   gatcc_adc_model i_adc (.src_clk_o(src), .trig_o(trg));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // pulse counts and spacings in clk cycles
   always @(posedge clk_i) begin
      n <= n + 1;
      if (gce === 1'b1) {pulses, gap, last} <= {pulses + 1, n - last, n};
      if (cpe === 1'b1) {cgap, clast} <= {n - clast, n};
   end
   task automatic chk(string what, logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // bready raised with the request, so the answer is taken at once
   task automatic wr(logic [31:0] a, d);
      logic ta, tw;
      {ta, tw} = 2'b00;
      @(posedge clk_i);
      {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
      do begin
         @(negedge clk_i);
         {ta, tw} = {ta | (awv & awr), tw | (wv & wr_o)};
         @(posedge clk_i);
         {awv, wv} <= {awv & !ta, wv & !tw};
      end while (!(ta && tw));
      do @(negedge clk_i); while (bv !== 1'b1);
      brv = br;
      @(posedge clk_i);
      bry <= 1'b0;
   endtask
   task automatic rdr(logic [31:0] a);
      @(posedge clk_i);
      {ara, arv, rry} <= {a, 2'b11};
      do @(negedge clk_i); while (arr !== 1'b1);
      @(posedge clk_i);
      arv <= 1'b0;
      do @(negedge clk_i); while (rv !== 1'b1);
      {rdv, rrv} = {rd, rr};
      @(posedge clk_i);
      rry <= 1'b0;
   endtask
   // one whole run: pulse total and spacing between pulses
   task automatic conv(int cnt, int sp);
      int p0;
      p0 = pulses;
      do @(negedge clk_i); while (run !== 1'b1);
      do @(negedge clk_i); while (run !== 1'b0);
      chk("pulses", pulses - p0, cnt + 1);
      chk("gap", gap, sp);
   endtask
   task automatic t_reset();
      rdr(32'h4);
      chk("ctrl1", rdv, 32'h02);
      rdr(32'h8);
      chk("ctrl2", rdv, 32'h0c);
      rdr(32'hc);
      chk("status", rdv, 32'h00);
      chk("resp ok", rrv, `GATCC_RESP_OKAY);
      rdr(32'h10);
      chk("resp", rrv, `GATCC_RESP_SLVERR);
      wr(32'hc, 32'h00);
      chk("bresp status", brv, `GATCC_RESP_SLVERR);
   endtask
   // every calibration code, divisors 0 to 3, bypass left at zero
   task automatic t_ctrl1();
      for (int k = 0; k < 4; k++) begin
         wr(32'h4, k * 9);
         chk("bresp ok", brv, `GATCC_RESP_OKAY);
         repeat (4) begin
            @(posedge clk_i);
            do @(negedge clk_i); while (cpe !== 1'b1);
         end
         chk("cp gap", cgap, 1 << k);
         chk("offset", ofc, k == 2);
         chk("bypass", shb, 1'b0);
      end
   endtask
   // counts 1,3,5,7 with every divide code; never below one
   task automatic t_sw();
      wr(32'h0, 32'h80);
      for (int i = 0; i < 4; i++) begin
         fork
            wr(32'h8, 32'h20 | (2 * i + 1) << 2 | i);
            conv(2 * i + 1, 8 << i);
         join
         rdr(32'h8);
         chk("ctrl2", rdv, (2 * i + 1) << 2 | i);
      end
   endtask
   task automatic t_hw();
      int p0;
      wr(32'h0, 32'h00);
      p0 = pulses;
      wr(32'h8, 32'h28);
      repeat (50) @(posedge clk_i);
      chk("sw in hw mode", pulses - p0, 0);
      chk("idle in hw mode", run, 1'b0);
      fork
         i_adc.fire();
         conv(2, 8);
      join
   endtask
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {reset_n_i, awv, wv, bry, arv, rry, awa, wd, ara} = '0;
      ws = 4'h1;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_ctrl1();
      t_sw();
      t_hw();
      results();
   end
   // watchdog well past the expected thousand or so cycles
   initial begin
      #2000000;
      miscompares++;
      results();
   end
endmodule // tb_top
`default_nettype wire
